// file: rtl/sit_pkg.sv
// constants for the spectral integration timing block
package sit_pkg;
  // byte register addresses
  localparam logic [7:0] ADDR_READBACK_LOW = 8'h63;
  localparam logic [7:0] ADDR_READBACK_MID = 8'h64;
  localparam logic [7:0] ADDR_READBACK_HIGH = 8'h65;
  localparam logic [7:0] ADDR_SYNC_EDGE_COUNT = 8'h72;
  localparam logic [7:0] ADDR_STEP_COUNT = 8'h81;
  localparam logic [7:0] ADDR_MEAS_WAIT = 8'h83;
  localparam logic [7:0] ADDR_STATUS_SIX = 8'hA7;
  localparam logic [7:0] ADDR_STEP_SIZE_LOW = 8'hCA;
  localparam logic [7:0] ADDR_STEP_SIZE_HIGH = 8'hCB;
  localparam logic [7:0] ADDR_FLICKER_LOW = 8'hD8;
  localparam logic [7:0] ADDR_FLICKER_HIGH_GAIN = 8'hDA;
  // reset values
  localparam logic [7:0] RST_STEP_COUNT = 8'h00;
  localparam logic [7:0] RST_MEAS_WAIT = 8'h00;
  localparam logic [7:0] RST_SYNC_EDGE_COUNT = 8'h00;
  localparam logic [15:0] RST_STEP_SIZE = 16'h03E7;
  localparam logic [7:0] RST_FLICKER_LOW = 8'h00;
  localparam logic [2:0] RST_FLICKER_TIME_HIGH = 3'h0;
  localparam logic [4:0] RST_FLICKER_GAIN = 5'h09;
  localparam logic [4:0] FLICKER_GAIN_MAX = 5'h0A;
  // field positions
  localparam int TRIG_ERR_BIT = 2;
  localparam int FLICKER_GAIN_LSB = 3;
  localparam int FLICKER_TIME_HIGH_MSB = 2;
  // integration mode codes
  localparam logic [1:0] MODE_FREE_RUNNING = 2'h0;
  localparam logic [1:0] MODE_SYNC_START = 2'h1;
  localparam logic [1:0] MODE_EDGE_SYNC = 2'h3;
  // saturation of the converter count
  localparam logic [15:0] FULL_SCALE_MAX = 16'hFFFF;
  // timing: figures in their own units, counts derived
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_TIME_NS = 2780;
  localparam int WAIT_CYCLE_TIME_US = 2780;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int WAIT_TICKS = (WAIT_CYCLE_TIME_US * 1000) / TICK_TIME_NS;
  localparam logic [9:0] TICK_LAST = 10'(TICK_CYCLES - 1);
  localparam logic [9:0] WAIT_TICK_LAST = 10'(WAIT_TICKS - 1);
  // sequencer states, one-hot
  typedef enum logic [2:0] {
    SIT_IDLE = 3'b001,
    SIT_INTEG = 3'b010,
    SIT_WAIT = 3'b100
  } sit_state_e;
endpackage

// file: rtl/sit_timing.sv
// integration timing sequencer with its byte register file
`timescale 1ns/100ps
module sit_timing
  import sit_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic power_on,
  input wire logic wait_enable,
  input wire logic flicker_enable,
  input wire logic [1:0] integ_mode,
  input wire logic [4:0] main_gain,
  input wire logic gpio_in,
  output logic integrating,
  output logic flicker_integrating,
  output logic [4:0] flicker_gain_used,
  output logic [15:0] full_scale,
  output logic trigger_timing_error
);

  // configuration registers and their next values
  logic [7:0] integ_step_count, next_integ_step_count;
  logic [7:0] measurement_wait, next_measurement_wait;
  logic [7:0] sync_edge_count, next_sync_edge_count;
  logic [15:0] integ_step_size, next_integ_step_size;
  logic [10:0] flicker_integ_time, next_flicker_integ_time;
  logic [4:0] flicker_gain, next_flicker_gain;

  // gpio synchroniser and debounced level
  logic sync_a, sync_b, sync_c;
  logic sync_level, next_sync_level;
  logic sync_fall; // one-cycle falling edge

  // sequencer state
  sit_state_e state, next_state;
  logic [9:0] tick_cnt, next_tick_cnt; // clock cycles within a tick
  logic [15:0] step_cnt, next_step_cnt; // ticks within a step
  logic [7:0] steps_done, next_steps_done; // steps finished
  logic [9:0] wait_tick, next_wait_tick; // ticks within a wait cycle
  logic [7:0] wait_cyc, next_wait_cyc; // wait cycles finished
  logic wait_run, next_wait_run; // wait period counting
  logic [7:0] edges_seen, next_edges_seen; // falling edges since start
  logic [23:0] sync_ticks, next_sync_ticks; // ticks since edge start
  logic [23:0] sync_integ_readback, next_sync_integ_readback;
  logic [10:0] flicker_cnt, next_flicker_cnt; // flicker ticks elapsed
  logic flicker_active, next_flicker_active;
  logic trig_err, next_trig_err;

  // output flop inputs and combinational helpers
  logic next_integrating, next_flicker_integrating;
  logic [4:0] next_flicker_gain_used;
  logic [15:0] next_full_scale;
  logic [7:0] next_reg_rdata;
  logic tick, start, integ_done, wait_hit;
  logic [24:0] product; // wide enough for 256 x 65536

  // synchroniser: first flop read only by the second
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      sync_c <= 1'b1;
    end else begin
      sync_a <= gpio_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // a level change counts once stages two and three agree
  always_comb begin
    next_sync_level = sync_level;
    if (sync_b == sync_c) begin
      next_sync_level = sync_c;
    end
    sync_fall = sync_level && (sync_b == sync_c) && !sync_c;
  end

  // register writes; reads return the selected byte
  always_comb begin
    next_integ_step_count = integ_step_count;
    next_measurement_wait = measurement_wait;
    next_sync_edge_count = sync_edge_count;
    next_integ_step_size = integ_step_size;
    next_flicker_integ_time = flicker_integ_time;
    next_flicker_gain = flicker_gain;
    if (reg_write) begin
      if (reg_addr == ADDR_STEP_COUNT) begin
        next_integ_step_count = reg_wdata;
      end else if (reg_addr == ADDR_MEAS_WAIT) begin
        next_measurement_wait = reg_wdata;
      end else if (reg_addr == ADDR_SYNC_EDGE_COUNT) begin
        next_sync_edge_count = reg_wdata;
      end else if (reg_addr == ADDR_STEP_SIZE_LOW) begin
        next_integ_step_size[7:0] = reg_wdata;
      end else if (reg_addr == ADDR_STEP_SIZE_HIGH) begin
        next_integ_step_size[15:8] = reg_wdata;
      end else if (reg_addr == ADDR_FLICKER_LOW) begin
        next_flicker_integ_time[7:0] = reg_wdata;
      end else if (reg_addr == ADDR_FLICKER_HIGH_GAIN) begin
        next_flicker_integ_time[10:8] =
          reg_wdata[FLICKER_TIME_HIGH_MSB:0];
        // codes past 512x are clamped, no higher gain exists
        if (reg_wdata[7:FLICKER_GAIN_LSB] > FLICKER_GAIN_MAX) begin
          next_flicker_gain = FLICKER_GAIN_MAX;
        end else begin
          next_flicker_gain = reg_wdata[7:FLICKER_GAIN_LSB];
        end
      end
    end
    next_reg_rdata = reg_rdata;
    if (reg_read) begin
      if (reg_addr == ADDR_READBACK_LOW) begin
        next_reg_rdata = sync_integ_readback[7:0];
      end else if (reg_addr == ADDR_READBACK_MID) begin
        next_reg_rdata = sync_integ_readback[15:8];
      end else if (reg_addr == ADDR_READBACK_HIGH) begin
        next_reg_rdata = sync_integ_readback[23:16];
      end else if (reg_addr == ADDR_SYNC_EDGE_COUNT) begin
        next_reg_rdata = sync_edge_count;
      end else if (reg_addr == ADDR_STEP_COUNT) begin
        next_reg_rdata = integ_step_count;
      end else if (reg_addr == ADDR_MEAS_WAIT) begin
        next_reg_rdata = measurement_wait;
      end else if (reg_addr == ADDR_STATUS_SIX) begin
        next_reg_rdata = 8'h00;
        next_reg_rdata[TRIG_ERR_BIT] = trig_err;
      end else if (reg_addr == ADDR_STEP_SIZE_LOW) begin
        next_reg_rdata = integ_step_size[7:0];
      end else if (reg_addr == ADDR_STEP_SIZE_HIGH) begin
        next_reg_rdata = integ_step_size[15:8];
      end else if (reg_addr == ADDR_FLICKER_LOW) begin
        next_reg_rdata = flicker_integ_time[7:0];
      end else if (reg_addr == ADDR_FLICKER_HIGH_GAIN) begin
        next_reg_rdata = {flicker_gain, flicker_integ_time[10:8]};
      end else begin
        next_reg_rdata = 8'h00; // unmapped reads as zero
      end
    end
  end

  // sequencer: tick, step, wait, edge and flicker counters
  always_comb begin
    next_state = state;
    next_tick_cnt = tick_cnt + 10'h001;
    next_step_cnt = step_cnt;
    next_steps_done = steps_done;
    next_wait_tick = wait_tick;
    next_wait_cyc = wait_cyc;
    next_wait_run = wait_run;
    next_edges_seen = edges_seen;
    next_sync_ticks = sync_ticks;
    next_sync_integ_readback = sync_integ_readback;
    next_flicker_cnt = flicker_cnt;
    next_flicker_active = flicker_active;
    next_trig_err = trig_err;
    // one shared tick base for every timer
    tick = (tick_cnt == TICK_LAST);
    if (tick) begin
      next_tick_cnt = 10'h000;
    end
    // wait period runs from a start while pacing stays on
    wait_hit = 1'b0;
    if (wait_run && wait_enable && tick) begin
      next_wait_tick = wait_tick + 10'h001;
      if (wait_tick == WAIT_TICK_LAST) begin
        next_wait_tick = 10'h000;
        next_wait_cyc = wait_cyc + 8'h01;
        if (wait_cyc == measurement_wait) begin
          wait_hit = 1'b1;
          next_wait_run = 1'b0;
        end
      end
    end
    // end of integration for the current mode
    if (integ_mode == MODE_EDGE_SYNC) begin
      integ_done = sync_fall && (edges_seen == sync_edge_count);
    end else begin
      integ_done = tick && (step_cnt == integ_step_size) &&
        (steps_done == integ_step_count);
    end
    start = 1'b0;
    case (state)
      SIT_IDLE: begin
        // free running starts at once, sync start and edge sync on a sync edge, code 2 never
        if (integ_mode == MODE_FREE_RUNNING) begin
          start = power_on;
        end else if ((integ_mode == MODE_SYNC_START) ||
                     (integ_mode == MODE_EDGE_SYNC)) begin
          start = power_on && sync_fall;
        end
      end
      SIT_INTEG: begin
        if (tick) begin
          next_step_cnt = step_cnt + 16'h0001;
          if (step_cnt == integ_step_size) begin
            next_step_cnt = 16'h0000;
            next_steps_done = steps_done + 8'h01;
          end
          next_sync_ticks = sync_ticks + 24'h000001;
        end
        if (sync_fall) begin
          next_edges_seen = edges_seen + 8'h01;
        end
        // period ran out before integration finished
        if (wait_hit) begin
          next_trig_err = 1'b1;
        end
        if (integ_done) begin
          if (integ_mode == MODE_EDGE_SYNC) begin
            next_sync_integ_readback = next_sync_ticks;
          end
          if (integ_mode != MODE_FREE_RUNNING) begin
            next_state = SIT_IDLE;
          end else if (wait_enable && next_wait_run) begin
            next_state = SIT_WAIT;
          end else begin
            start = 1'b1;
          end
        end
      end
      SIT_WAIT: begin
        if (wait_hit || !wait_enable) begin
          start = 1'b1;
        end
      end
      default: begin
        next_state = SIT_IDLE;
      end
    endcase
    if (start) begin
      next_state = SIT_INTEG;
      next_tick_cnt = 10'h000;
      next_step_cnt = 16'h0000;
      next_steps_done = 8'h00;
      next_edges_seen = 8'h00;
      next_sync_ticks = 24'h000000;
      next_wait_tick = 10'h000;
      next_wait_cyc = 8'h00;
      next_wait_run = wait_enable;
      next_flicker_cnt = 11'h000;
      next_flicker_active = (flicker_integ_time != 11'h000);
    end else if (flicker_active && tick) begin
      next_flicker_cnt = flicker_cnt + 11'h001;
      if (next_flicker_cnt == flicker_integ_time) begin
        next_flicker_active = 1'b0;
      end
    end
    if (!power_on) begin
      next_state = SIT_IDLE;
      next_wait_run = 1'b0;
      next_flicker_active = 1'b0;
    end
    // software clear loses to a same-cycle set
    if (reg_write && (reg_addr == ADDR_STATUS_SIX) &&
        reg_wdata[TRIG_ERR_BIT] && !(state == SIT_INTEG && wait_hit)) begin
      next_trig_err = 1'b0;
    end
  end

  // full scale, saturated outputs and flicker steering
  always_comb begin
    product = (25'(integ_step_count) + 25'h0000001) *
              (25'(integ_step_size) + 25'h0000001);
    if (product > {9'h000, FULL_SCALE_MAX}) begin
      next_full_scale = FULL_SCALE_MAX;
    end else begin
      next_full_scale = product[15:0];
    end
    next_integrating = (next_state == SIT_INTEG);
    // without flicker enable the flicker channel shadows the main one
    if (flicker_enable) begin
      next_flicker_integrating = next_flicker_active;
      next_flicker_gain_used = flicker_gain;
    end else begin
      next_flicker_integrating = next_integrating;
      next_flicker_gain_used = main_gain;
    end
  end

  // register stage for all state except the gpio synchroniser
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      integ_step_count <= RST_STEP_COUNT;
      measurement_wait <= RST_MEAS_WAIT;
      sync_edge_count <= RST_SYNC_EDGE_COUNT;
      integ_step_size <= RST_STEP_SIZE;
      flicker_integ_time <= {RST_FLICKER_TIME_HIGH, RST_FLICKER_LOW};
      flicker_gain <= RST_FLICKER_GAIN;
      sync_level <= 1'b1;
      state <= SIT_IDLE;
      tick_cnt <= 10'h000;
      step_cnt <= 16'h0000;
      steps_done <= 8'h00;
      wait_tick <= 10'h000;
      wait_cyc <= 8'h00;
      wait_run <= 1'b0;
      edges_seen <= 8'h00;
      sync_ticks <= 24'h000000;
      sync_integ_readback <= 24'h000000;
      flicker_cnt <= 11'h000;
      flicker_active <= 1'b0;
      trig_err <= 1'b0;
      integrating <= 1'b0;
      flicker_integrating <= 1'b0;
      flicker_gain_used <= RST_FLICKER_GAIN;
      full_scale <= 16'h0000;
      trigger_timing_error <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      integ_step_count <= next_integ_step_count;
      measurement_wait <= next_measurement_wait;
      sync_edge_count <= next_sync_edge_count;
      integ_step_size <= next_integ_step_size;
      flicker_integ_time <= next_flicker_integ_time;
      flicker_gain <= next_flicker_gain;
      sync_level <= next_sync_level;
      state <= next_state;
      tick_cnt <= next_tick_cnt;
      step_cnt <= next_step_cnt;
      steps_done <= next_steps_done;
      wait_tick <= next_wait_tick;
      wait_cyc <= next_wait_cyc;
      wait_run <= next_wait_run;
      edges_seen <= next_edges_seen;
      sync_ticks <= next_sync_ticks;
      sync_integ_readback <= next_sync_integ_readback;
      flicker_cnt <= next_flicker_cnt;
      flicker_active <= next_flicker_active;
      trig_err <= next_trig_err;
      integrating <= next_integrating;
      flicker_integrating <= next_flicker_integrating;
      flicker_gain_used <= next_flicker_gain_used;
      full_scale <= next_full_scale;
      trigger_timing_error <= next_trig_err;
      reg_rdata <= next_reg_rdata;
    end
  end

endmodule

// file: test/sit_host_model.sv
// host controller model driving the byte register port
`timescale 1ns/100ps
module sit_host_model (
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read,
  input wire logic clock,
  input wire logic [7:0] reg_rdata
);
  // quiet port from time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  // one strobe cycle, then an idle edge so a strobe never rises twice in
  // a step; callers never send all-ones step size, never zero both step
  // fields, and leave flicker time alone while it runs
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask
  // data is registered, taken one edge after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
    v = reg_rdata;
  endtask
endmodule

// file: test/sit_timing_properties.sv
// port-level assertion checker for the integration timing block
`timescale 1ns/100ps
module sit_timing_checker
  import sit_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic power_on,
  input wire logic wait_enable,
  input wire logic flicker_enable,
  input wire logic [1:0] integ_mode,
  input wire logic [4:0] main_gain,
  input wire logic gpio_in,
  input wire logic integrating,
  input wire logic [4:0] flicker_gain_used,
  input wire logic [15:0] full_scale,
  input wire logic trigger_timing_error
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic gpio_prev; // pin level one edge ago
  logic next_gpio_prev;
  logic [3:0] since_fall; // edges since a pin fall, saturating
  logic [3:0] next_since_fall;
  logic [15:0] hi_cnt; // length of the current integrating run
  logic [15:0] next_hi_cnt;
  // saturate so a long quiet pin never wraps to a false recent fall
  always_comb begin
    next_gpio_prev = gpio_in;
    next_since_fall = (since_fall == 4'hF) ? since_fall : since_fall + 4'h1;
    next_hi_cnt = integrating ? hi_cnt + 16'h0001 : 16'h0000;
    if (gpio_prev && !gpio_in) begin
      next_since_fall = 4'h0;
    end
    if (!rst_n) begin
      next_gpio_prev = 1'b1;
      next_since_fall = 4'hF;
      next_hi_cnt = 16'h0000;
    end
  end
  // helper registers only
  always_ff @(posedge clock) begin
    gpio_prev <= next_gpio_prev;
    since_fall <= next_since_fall;
    hi_cnt <= next_hi_cnt;
  end
  a_reset_gain_idle: assert property ($rose(rst_n) |->
    flicker_gain_used == RST_FLICKER_GAIN && !integrating)
    else $error("reset state of gain or integration wrong");
  a_gain_follows_main: assert property ($past(rst_n) &&
    !$past(flicker_enable) |-> flicker_gain_used == $past(main_gain))
    else $error("flicker gain does not follow main gain");
  a_gain_in_range: assert property ($past(rst_n) &&
    $past(flicker_enable) |-> flicker_gain_used <= FLICKER_GAIN_MAX)
    else $error("flicker gain code above range");
  a_scale_needs_write: assert property ($changed(full_scale) &&
    $past(rst_n, 2) |-> $past(reg_write) || $past(reg_write, 2))
    else $error("full scale moved without a write");
  a_edge_stop_cause: assert property ($fell(integrating) && power_on &&
    integ_mode == MODE_EDGE_SYNC |-> since_fall <= 4'hC)
    else $error("edge mode stopped without a pin fall");
  a_sync_start_cause: assert property ($rose(integrating) &&
    integ_mode != MODE_FREE_RUNNING |-> since_fall <= 4'hC)
    else $error("synced start without a pin fall");
  a_tick_whole_run: assert property ($fell(integrating) && power_on &&
    $past(power_on) && integ_mode != MODE_EDGE_SYNC |->
    hi_cnt % TICK_CYCLES == 0)
    else $error("timed run not a whole number of ticks");
  a_err_clear_write: assert property ($fell(trigger_timing_error) |->
    $past(reg_write) && $past(reg_addr) == ADDR_STATUS_SIX)
    else $error("error flag cleared without a status write");
  a_err_needs_wait: assert property ($rose(trigger_timing_error) |->
    $past(wait_enable))
    else $error("error flag set with wait pacing off");
endmodule
bind sit_timing sit_timing_checker chk_i (
  .clock(clock),
  .rst_n(rst_n),
  .reg_addr(reg_addr),
  .reg_write(reg_write),
  .power_on(power_on),
  .wait_enable(wait_enable),
  .flicker_enable(flicker_enable),
  .integ_mode(integ_mode),
  .main_gain(main_gain),
  .gpio_in(gpio_in),
  .integrating(integrating),
  .flicker_gain_used(flicker_gain_used),
  .full_scale(full_scale),
  .trigger_timing_error(trigger_timing_error)
);

// file: test/sit_timing_tb.sv
// self-checking bench for the integration timing block
`timescale 1ns/100ps
module sit_timing_tb;
  import sit_pkg::*;
  // address and reset value pairs, last one unmapped
  localparam logic [15:0] RST_TAB [12] = '{16'h6300, 16'h6400, 16'h6500,
    16'h7200, 16'h8100, 16'h8300, 16'hCAE7, 16'hCB03, 16'hD800,
    16'hDA48, 16'hA700, 16'h9000};
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic power_on = 1'b0;
  logic wait_enable = 1'b0; // pacing stays off, its period is too long
  logic flicker_enable = 1'b0;
  logic gpio_in = 1'b1;
  logic [1:0] integ_mode = MODE_SYNC_START;
  logic [4:0] main_gain = 5'h03;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic reg_write, reg_read, integrating, flicker_integrating;
  logic trigger_timing_error;
  logic [4:0] flicker_gain_used;
  logic [15:0] full_scale;
  int num_errors = 0;
  int checked = 0;
  int n, fn;
  initial forever #2 clock = ~clock;
  sit_host_model host (.clock(clock), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata));
  sit_timing uut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .power_on(power_on), .wait_enable(wait_enable),
    .flicker_enable(flicker_enable), .integ_mode(integ_mode),
    .main_gain(main_gain), .gpio_in(gpio_in), .integrating(integrating),
    .flicker_integrating(flicker_integrating),
    .flicker_gain_used(flicker_gain_used), .full_scale(full_scale),
    .trigger_timing_error(trigger_timing_error));
  // one comparison, counted
  task automatic chk(input string nm, input logic [23:0] s, e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d);
    chk("register", 24'(d), 24'(e));
  endtask
  // step fields, then the registered full scale
  task automatic cfg(input logic [7:0] c, lo, hi, input logic [15:0] e);
    host.wr(ADDR_STEP_COUNT, c);
    host.wr(ADDR_STEP_SIZE_LOW, lo);
    host.wr(ADDR_STEP_SIZE_HIGH, hi);
    @(negedge clock);
    chk("full_scale", 24'(full_scale), 24'(e));
    @(posedge clock);
  endtask
  // counts high cycles of one run, sampled at falling edges
  task automatic meas;
    n = 0;
    fn = 0;
    for (int i = 0; i < 100 && integrating !== 1'b1; i++) @(negedge clock);
    for (int i = 0; i < 3000 && integrating === 1'b1; i++) begin
      n++;
      if (flicker_integrating === 1'b1) fn++;
      @(negedge clock);
    end
    if (n == 0 || integrating !== 1'b0) begin
      num_errors++;
      report_and_stop;
    end
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge clock);
    num_errors++;
    report_and_stop;
  end
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk("reset full_scale", 24'(full_scale), 24'd1000);
    @(posedge clock);
    for (int i = 0; i < 12; i++) begin
      rdc(RST_TAB[i][15:8], RST_TAB[i][7:0]);
    end
    cfg(8'hFF, 8'hFF, 8'h00, 16'hFFFF);
    cfg(8'h02, 8'h09, 8'h00, 16'd30);
    cfg(8'h01, 8'hFE, 8'h7F, 16'hFFFE);
    flicker_enable <= 1'b1;
    for (int g = 0; g < 12; g++) begin
      host.wr(ADDR_FLICKER_HIGH_GAIN, {5'(g), 3'h5});
      rdc(ADDR_FLICKER_HIGH_GAIN, {(g > 10) ? 5'h0A : 5'(g), 3'h5});
      chk("gain", 24'(flicker_gain_used), (g > 10) ? 24'hA : 24'(g));
    end
    flicker_enable <= 1'b0;
    repeat (2) @(posedge clock);
    chk("gain off", 24'(flicker_gain_used), 24'h03);
    host.wr(ADDR_FLICKER_HIGH_GAIN, 8'h48);
    host.wr(ADDR_FLICKER_LOW, 8'h01);
    host.wr(ADDR_READBACK_LOW, 8'h5A);
    rdc(ADDR_READBACK_LOW, 8'h00);
    host.wr(ADDR_MEAS_WAIT, 8'hFF);
    rdc(ADDR_MEAS_WAIT, 8'hFF);
    host.wr(ADDR_SYNC_EDGE_COUNT, 8'h01);
    rdc(ADDR_SYNC_EDGE_COUNT, 8'h01);
    // sync start, two ticks main and one tick flicker
    cfg(8'h01, 8'h00, 8'h00, 16'h0002);
    flicker_enable <= 1'b1;
    power_on <= 1'b1;
    @(posedge clock);
    gpio_in <= 1'b0;
    meas;
    chk("integ cycles", 24'(n), 24'(2 * TICK_CYCLES));
    chk("flicker cycles", 24'(fn), 24'(TICK_CYCLES));
    @(posedge clock);
    gpio_in <= 1'b1;
    integ_mode <= MODE_EDGE_SYNC;
    repeat (20) @(posedge clock);
    // edge mode: start fall plus two more, three ticks apart
    for (int k = 0; k < 3; k++) begin
      gpio_in <= 1'b0;
      repeat (20) @(posedge clock);
      gpio_in <= 1'b1;
      chk("edge integ", 24'(integrating), 24'(k < 2));
      repeat (3 * TICK_CYCLES - 20) @(posedge clock);
    end
    // two gaps of three ticks between start and stop falls
    rdc(ADDR_READBACK_LOW, 8'h06);
    rdc(ADDR_READBACK_MID, 8'h00);
    rdc(ADDR_READBACK_HIGH, 8'h00);
    // free running with pacing off restarts at once, never a low cycle
    integ_mode <= MODE_FREE_RUNNING;
    repeat (2) @(posedge clock);
    n = 0;
    repeat (3 * TICK_CYCLES) begin
      @(negedge clock);
      if (integrating !== 1'b1) n++;
    end
    chk("free running gaps", 24'(n), 24'h0);
    chk("trigger error", 24'(trigger_timing_error), 24'h0);
    @(posedge clock);
    power_on <= 1'b0;
    repeat (2) @(posedge clock);
    chk("power off", 24'(integrating), 24'h0);
    report_and_stop;
  end
endmodule
